// ==== hdl/luc_core.sv ====
`timescale 1ns/1ps
// Behaviour
// - register AND decoded from group A, function and bit 10 zero
// - register AND writes rs AND rt into rd, no exception
// - mask-immediate decoded from its opcode, result to target register
// - mask-immediate zero-extends the 16-bit immediate before AND
// - upper add: immediate shifted 16, added to source, no overflow trap
// - source field zero makes upper add load the shifted immediate
// - pc upper add: shifted immediate plus this instruction address
// - call: offset field shifted one, added to next address, into PC
// - call writes next address into register 31
// - taken compact branch skips following instruction, goes to target
// - any instruction may follow a compact branch, no restriction
// - fp bit branches decoded from group I sub-opcodes 01000, 01001
// - fp branch tests only bit 0 of selected float register
// - branch offset shifted one, sign-extended, added to next address
// - false condition continues with next sequential instruction
// - fp branch with coprocessor disabled raises coprocessor unusable
// - fp bit branches never raise reserved instruction when fpu present
// - cop2 branch sends 5-bit index, taken per returned condition
// - cop2 disabled raises coprocessor unusable instead of evaluating
module luc_core
   import luc_pkg::*;
(
   input  wire logic            clock,
   input  wire logic            rst,
   input  wire logic            instr_valid,
   input  wire logic [XLEN-1:0] instr,
   output logic                 instr_ready,
   output logic      [XLEN-1:0] pc,
   output logic                 pc_redirect,
   output logic      [4:0]      fp_reg_index,
   input  wire logic [XLEN-1:0] fp_reg_data,
   output logic      [4:0]      cop2_cond_index,
   input  wire logic            cop2_cond,
   input  wire logic            fpu_present,
   input  wire logic            fpu_enable,
   input  wire logic            cop2_enable,
   output logic                 exc_valid,
   output logic      [2:0]      exc_code,
   output logic                 unknown_instr,
   input  wire logic [4:0]      dbg_reg_addr,
   output logic      [XLEN-1:0] dbg_reg_data
);
   typedef enum logic [1:0] {LUC_FETCH, LUC_READ, LUC_EXEC} luc_state_e;

   luc_state_e      state_q;
   logic [XLEN-1:0] ir_q;
   logic [XLEN-1:0] pc_q;
   logic [XLEN-1:0] rs_val;
   logic [XLEN-1:0] rt_val;
   logic [4:0]      rd_a_addr;
   logic [4:0]      rd_b_addr;
   logic            wr_en;
   logic [4:0]      wr_addr;
   logic [XLEN-1:0] wr_data;
   logic [5:0]      opc;
   logic [4:0]      f25;
   logic [4:0]      f20;
   logic [4:0]      f15;
   logic [15:0]     imm;
   logic [XLEN-1:0] pc_next;
   logic [XLEN-1:0] upper_imm;
   logic [XLEN-1:0] br_off;
   logic [XLEN-1:0] call_off;
   logic            is_and;
   logic            is_maski;
   logic            is_upadd;
   logic            is_uppc;
   logic            is_call;
   logic            is_gi;
   logic            cond_taken;
   logic            cond_fp;
   logic            cond_c2;
   logic            fp_unusable;
   logic            c2_unusable;
   logic            br_taken;
   logic            exec;
   logic            exc_d;
   logic [2:0]      exc_code_d;
   logic            redirect_d;

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   assign opc       = ir_q[OPC_HI:OPC_LO];
   assign f25       = ir_q[F25_HI:F25_LO];
   assign f20       = ir_q[F20_HI:F20_LO];
   assign f15       = ir_q[RD_HI:RD_LO];
   assign imm       = ir_q[IMM_HI:0];
   assign exec      = (state_q == LUC_EXEC);
   assign pc_next   = pc_q + PC_STEP;
   assign upper_imm = {imm, 16'h0000};
   assign br_off    = {{15{imm[15]}}, imm, 1'b0};
   assign call_off  = {{5{ir_q[OFF26_HI]}}, ir_q[OFF26_HI:0], 1'b0};
   assign is_and    = (opc == OPC_GROUP_A) && !ir_q[BIT10] && (ir_q[FUNC_HI:FUNC_LO] == FUNC_AND);
   assign is_maski  = (opc == OPC_MASKI);
   assign is_upadd  = (opc == OPC_UPADD);
   assign is_uppc   = (opc == OPC_PC_RELATIVE_GROUP) && (f20 == SUB_UPPC);
   assign is_call   = (opc == OPC_CALL);
   assign is_gi     = (opc == OPC_GROUP_I) && (cond_fp || cond_c2);
   // no reserved trap when present
   // sub-op field alone also matches other opcodes, so the group is checked too
   assign fp_unusable = (opc == OPC_GROUP_I) && cond_fp && (!fpu_enable || !fpu_present);
   assign c2_unusable = (opc == OPC_GROUP_I) && cond_c2 && !cop2_enable;
   assign br_taken    = is_gi && cond_taken && !fp_unusable && !c2_unusable;

   assign fp_reg_index    = f20;
   assign cop2_cond_index = f20;
   // operands read from the held word in read state, so execute sees them
   assign rd_a_addr   = ir_q[F20_HI:F20_LO];
   assign rd_b_addr   = ir_q[F25_HI:F25_LO];
   assign instr_ready = (state_q == LUC_FETCH);
   assign pc          = pc_q;

   luc_cond u_cond
   (
      .fp_bit0   (fp_reg_data[0]),
      .cop2_cond (cop2_cond),
      .sub_op    (f25),
      .taken     (cond_taken),
      .is_fp     (cond_fp),
      .is_cop2   (cond_c2)
   );

   luc_regfile u_regs
   (
      .clock     (clock),
      .rst       (rst),
      .rd_a_addr ((state_q == LUC_READ) ? rd_a_addr : dbg_reg_addr),
      .rd_b_addr (rd_b_addr),
      .rd_a_data (rs_val),
      .rd_b_data (rt_val),
      .wr_en     (wr_en),
      .wr_addr   (wr_addr),
      .wr_data   (wr_data)
   );

   // ----------------------------------------------------------------
   // write back
   // ----------------------------------------------------------------
   always_comb
   begin
      wr_en   = 1'b0;
      wr_addr = f25;
      wr_data = '0;
      if (exec)
      begin
         if (is_and)
         begin
            wr_en   = 1'b1;
            wr_addr = f15;
            wr_data = rs_val & rt_val;
         end
         else if (is_maski)
         begin
            wr_en   = 1'b1;
            wr_data = rs_val & {16'h0000, imm};
         end
         else if (is_upadd)
         begin
            wr_en   = 1'b1;
            wr_data = rs_val + upper_imm;
         end
         else if (is_uppc)
         begin
            wr_en   = 1'b1;
            wr_data = pc_q + upper_imm;
         end
         else if (is_call)
         begin
            wr_en   = 1'b1;
            wr_addr = LINK_REG;
            wr_data = pc_next;
         end
      end
   end

   always_comb
   begin
      exc_d      = 1'b0;
      exc_code_d = LUC_EXC_NONE;
      redirect_d = 1'b0;
      if (exec)
      begin
         if (fp_unusable || c2_unusable)
         begin
            exc_d      = 1'b1;
            exc_code_d = LUC_EXC_CPU;
         end
         redirect_d = is_call || br_taken;
      end
   end

   // ----------------------------------------------------------------
   // sequencing
   // ----------------------------------------------------------------
   // every path returns to fetch
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         state_q <= LUC_FETCH;
         ir_q    <= '0;
      end
      else
      begin
         unique case (state_q)
            LUC_FETCH:
            begin
               if (instr_valid)
               begin
                  ir_q    <= instr;
                  state_q <= LUC_READ;
               end
            end
            LUC_READ: state_q <= LUC_EXEC;
            LUC_EXEC: state_q <= LUC_FETCH;
         endcase
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         pc_q <= PC_RESET;
      end
      else if (exec)
      begin
         if (is_call)
            pc_q <= pc_next + call_off;
         else if (br_taken)
            pc_q <= pc_next + br_off;
         else
            pc_q <= pc_next;
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         pc_redirect   <= 1'b0;
         exc_valid     <= 1'b0;
         exc_code      <= LUC_EXC_NONE;
         unknown_instr <= 1'b0;
         dbg_reg_data  <= '0;
      end
      else
      begin
         pc_redirect   <= redirect_d;
         exc_valid     <= exc_d;
         exc_code      <= exc_code_d;
         unknown_instr <= exec && !(is_and || is_maski || is_upadd || is_uppc || is_call || is_gi);
         // port a serves the debug address outside read state; result held per instruction
         dbg_reg_data  <= (state_q == LUC_READ) ? rs_val : dbg_reg_data;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   call_link_a: assert property (@(posedge clock) disable iff (rst)
      exec && is_call |-> wr_en && wr_addr == LINK_REG && wr_data == pc_q + PC_STEP)
      else $error("call link wrong");
   call_target_a: assert property (@(posedge clock) disable iff (rst)
      exec && is_call |=> pc_q == $past(pc_q) + PC_STEP + $past(call_off))
      else $error("call target wrong");
   branch_target_a: assert property (@(posedge clock) disable iff (rst)
      exec && br_taken |=> pc_q == $past(pc_q) + PC_STEP + $past(br_off))
      else $error("branch target wrong");
   not_taken_a: assert property (@(posedge clock) disable iff (rst)
      exec && is_gi && !br_taken |=> pc_q == $past(pc_q) + PC_STEP)
      else $error("fall through wrong");
   fp_unusable_a: assert property (@(posedge clock) disable iff (rst)
      exec && is_gi && cond_fp && !fpu_enable |=> exc_valid && exc_code == LUC_EXC_CPU)
      else $error("fp unusable missed");
   no_reserved_a: assert property (@(posedge clock) disable iff (rst)
      exc_valid |-> exc_code != LUC_EXC_RI)
      else $error("reserved raised");
   c2_unusable_a: assert property (@(posedge clock) disable iff (rst)
      exec && is_gi && cond_c2 && !cop2_enable |-> !br_taken ##1 exc_valid)
      else $error("cop2 unusable missed");
   and_result_a: assert property (@(posedge clock) disable iff (rst)
      exec && is_and |-> wr_addr == f15 && wr_data == (rs_val & rt_val))
      else $error("and result wrong");
   mask_imm_a: assert property (@(posedge clock) disable iff (rst)
      exec && is_maski |-> wr_data[31:16] == 16'h0000)
      else $error("mask not zero extended");
   uppc_a: assert property (@(posedge clock) disable iff (rst)
      exec && is_uppc |-> wr_data[15:0] == pc_q[15:0])
      else $error("pc upper add wrong");
   fetch_cycle_a: assert property (@(posedge clock) disable iff (rst)
      instr_ready && instr_valid |=> !instr_ready [*2] ##1 instr_ready)
      else $error("sequence length wrong");
   call_c: cover property (@(posedge clock) disable iff (rst) exec && is_call);
   fp_taken_c: cover property (@(posedge clock) disable iff (rst) exec && cond_fp && br_taken);
   c2_fall_c: cover property (@(posedge clock) disable iff (rst) exec && cond_c2 && !br_taken);
   back_to_back_c: cover property (@(posedge clock) disable iff (rst)
      exec && br_taken ##[1:4] (instr_ready && instr_valid) ##2 exec && br_taken);
endmodule

// ==== inc/luc_pkg.sv ====
package luc_pkg;
   localparam int XLEN = 32;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int OPC_HI   = 31;
   localparam int OPC_LO   = 26;
   localparam int F25_HI   = 25;
   localparam int F25_LO   = 21;
   localparam int F20_HI   = 20;
   localparam int F20_LO   = 16;
   localparam int RD_HI    = 15;
   localparam int RD_LO    = 11;
   localparam int FUNC_HI  = 9;
   localparam int FUNC_LO  = 0;
   localparam int BIT10    = 10;
   localparam int IMM_HI   = 15;
   localparam int OFF26_HI = 25;
   // ----------------------------------------------------------------
   // encodings
   // ----------------------------------------------------------------
   localparam logic [5:0] OPC_GROUP_A = 6'h00;
   localparam logic [5:0] OPC_MASKI   = 6'h34;
   localparam logic [5:0] OPC_UPADD   = 6'h04;
   localparam logic [5:0] OPC_PC_RELATIVE_GROUP   = 6'h1e;
   localparam logic [5:0] OPC_CALL    = 6'h2d;
   localparam logic [5:0] OPC_GROUP_I = 6'h11;
   localparam logic [9:0] FUNC_AND    = 10'h250;
   localparam logic [4:0] SUB_UPPC    = 5'h1e;
   localparam logic [4:0] SUB_FPZ     = 5'h08;
   localparam logic [4:0] SUB_FPS     = 5'h09;
   localparam logic [4:0] SUB_C2F     = 5'h0a;
   localparam logic [4:0] SUB_C2T     = 5'h0b;
   localparam logic [4:0] LINK_REG    = 5'h1f;
   localparam logic [4:0] ZERO_REG    = 5'h00;
   localparam logic [XLEN-1:0] PC_STEP   = 32'h0000_0004;
   localparam logic [XLEN-1:0] PC_RESET  = 32'h0000_0000;
   typedef enum logic [2:0] {LUC_EXC_NONE, LUC_EXC_CPU, LUC_EXC_RI} luc_exc_e;
endpackage

// ==== hdl/luc_regfile.sv ====
`timescale 1ns/1ps
module luc_regfile
   import luc_pkg::*;
(
   input  wire logic            clock,
   input  wire logic            rst,
   input  wire logic [4:0]      rd_a_addr,
   input  wire logic [4:0]      rd_b_addr,
   output logic      [XLEN-1:0] rd_a_data,
   output logic      [XLEN-1:0] rd_b_data,
   input  wire logic            wr_en,
   input  wire logic [4:0]      wr_addr,
   input  wire logic [XLEN-1:0] wr_data
);
   logic [XLEN-1:0] mem_q [32];

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   // zero register kept
   always_ff @(posedge clock)
   begin
      if (wr_en && wr_addr != ZERO_REG)
      begin
         mem_q[wr_addr] <= wr_data;
      end
   end

   // registered reads; zero register forced so no reset of the array is needed
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         rd_a_data <= '0;
         rd_b_data <= '0;
      end
      else
      begin
         rd_a_data <= (rd_a_addr == ZERO_REG) ? '0 : mem_q[rd_a_addr];
         rd_b_data <= (rd_b_addr == ZERO_REG) ? '0 : mem_q[rd_b_addr];
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   zero_reg_a: assert property (@(posedge clock) disable iff (rst)
      $past(rd_a_addr) == ZERO_REG |-> rd_a_data == '0)
      else $error("register zero read non-zero");
endmodule

// ==== hdl/luc_cond.sv ====
`timescale 1ns/1ps
module luc_cond
   import luc_pkg::*;
(
   input  wire logic       fp_bit0,
   input  wire logic       cop2_cond,
   input  wire logic [4:0] sub_op,
   output logic            taken,
   output logic            is_fp,
   output logic            is_cop2
);
   // ----------------------------------------------------------------
   // compact branch condition
   // ----------------------------------------------------------------
   always_comb
   begin
      is_fp   = (sub_op == SUB_FPZ) || (sub_op == SUB_FPS);
      is_cop2 = (sub_op == SUB_C2F) || (sub_op == SUB_C2T);
      unique case (sub_op)
         SUB_FPZ: taken = ~fp_bit0;
         SUB_FPS: taken = fp_bit0;
         SUB_C2F: taken = ~cop2_cond;
         SUB_C2T: taken = cop2_cond;
         default: taken = 1'b0;
      endcase
   end
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench
   import luc_pkg::*;
;
   logic            clock;
   logic            rst;
   logic            instr_valid;
   logic [XLEN-1:0] instr;
   logic            instr_ready;
   logic [XLEN-1:0] pc;
   logic            pc_redirect;
   logic [4:0]      fp_reg_index;
   logic [XLEN-1:0] fp_reg_data;
   logic [4:0]      cop2_cond_index;
   logic            cop2_cond;
   logic            fpu_present;
   logic            fpu_enable;
   logic            cop2_enable;
   logic            exc_valid;
   logic [2:0]      exc_code;
   logic            unknown_instr;
   logic [4:0]      dbg_reg_addr;
   logic [XLEN-1:0] dbg_reg_data;
   int              errors;
   int              samples_checked;
   logic [XLEN-1:0] exp_pc;
   logic [XLEN-1:0] p0;
   logic [4:0]      sub;
   logic            c;
   logic            tk;

`define CHK(nm, exp, got) \
   begin \
      samples_checked++; \
      if ((got) !== (exp)) \
      begin \
         errors++; \
         $display("mismatch %s expected %h seen %h", nm, exp, got); \
      end \
   end

   luc_core u_dut (
      .clock           (clock),
      .rst             (rst),
      .instr_valid     (instr_valid),
      .instr           (instr),
      .instr_ready     (instr_ready),
      .pc              (pc),
      .pc_redirect     (pc_redirect),
      .fp_reg_index    (fp_reg_index),
      .fp_reg_data     (fp_reg_data),
      .cop2_cond_index (cop2_cond_index),
      .cop2_cond       (cop2_cond),
      .fpu_present     (fpu_present),
      .fpu_enable      (fpu_enable),
      .cop2_enable     (cop2_enable),
      .exc_valid       (exc_valid),
      .exc_code        (exc_code),
      .unknown_instr   (unknown_instr),
      .dbg_reg_addr    (dbg_reg_addr),
      .dbg_reg_data    (dbg_reg_data)
   );

   initial
   begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   // ----------------------------------------------------------------
   // access tasks
   // ----------------------------------------------------------------
   task automatic give_verdict();
      $display("counts: %0d compared, %0d mismatched", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic end_test(input string s);
      $display("test %s finished, %0d mismatches so far", s, errors);
   endtask

   function automatic logic [XLEN-1:0] itype(input logic [5:0] op, input logic [4:0] t, input logic [4:0] s,
                                             input logic [15:0] imm);
      return {op, t, s, imm};
   endfunction

   // f = {skip pc, redirect, exception, unknown}; results seen in the cycle after execute
   task automatic run(input logic [XLEN-1:0] w, input logic [XLEN-1:0] npc, input logic [3:0] f);
      int n;
      n = 0;
      while (instr_ready !== 1'b1 && n < 20)
      begin
         @(posedge clock);
         #1;
         n++;
      end
      if (n >= 20)
      begin
         errors++;
         give_verdict();
      end
      @(posedge clock);
      instr_valid <= 1'b1;
      instr       <= w;
      @(posedge clock);
      instr_valid <= 1'b0;
      #1;
      `CHK("cond_index", w[20:16], cop2_cond_index)
      `CHK("fp_index", w[20:16], fp_reg_index)
      repeat (2) @(posedge clock);
      #1;
      `CHK("redirect", f[2], pc_redirect)
      `CHK("exc_valid", f[1], exc_valid)
      `CHK("unknown", f[0], unknown_instr)
      if (f[1])
         `CHK("exc_code", 3'(LUC_EXC_CPU), exc_code)
      if (!f[3])
      begin
         `CHK("pc", npc, pc)
         exp_pc = npc;
      end
   endtask

   // unknown opcode carries the register in both source fields so any read port shows it
   task automatic rd(input logic [4:0] r, input logic [XLEN-1:0] v);
      @(posedge clock);
      dbg_reg_addr <= r;
      run({6'h3f, r, r, 16'h0000}, exp_pc + PC_STEP, 4'b0001);
      `CHK("reg", v, dbg_reg_data)
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      errors = 0;
      samples_checked = 0;
      rst = 1'b1;
      instr_valid = 1'b0;
      instr = '0;
      fp_reg_data = '0;
      cop2_cond = 1'b0;
      fpu_present = 1'b1;
      fpu_enable = 1'b1;
      cop2_enable = 1'b1;
      dbg_reg_addr = '0;
      exp_pc = '0;
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      #1;
      `CHK("pc_reset", PC_RESET, pc)
      `CHK("ready_reset", 1'b1, instr_ready)
      end_test("reset");

      run(itype(OPC_UPADD, 5'h01, 5'h00, 16'hf0f0), 32'h0000_0004, 4'b0000);
      run(itype(OPC_UPADD, 5'h02, 5'h01, 16'h1234), 32'h0000_0008, 4'b0000);
      run(itype(OPC_PC_RELATIVE_GROUP, 5'h03, SUB_UPPC, 16'h8001), 32'h0000_000c, 4'b0000);
      run(itype(OPC_MASKI, 5'h04, 5'h03, 16'hffff), 32'h0000_0010, 4'b0000);
      run({OPC_GROUP_A, 5'h03, 5'h01, 5'h05, 1'b0, FUNC_AND}, 32'h0000_0014, 4'b0000);
      run({OPC_GROUP_A, 5'h01, 5'h01, 5'h00, 1'b0, FUNC_AND}, 32'h0000_0018, 4'b0000);
      run({OPC_GROUP_A, 5'h01, 5'h01, 5'h06, 1'b1, FUNC_AND}, 32'h0000_001c, 4'b0001);
      rd(5'h01, 32'hf0f0_0000);
      rd(5'h02, 32'h0324_0000);
      rd(5'h03, 32'h8001_0008);
      rd(5'h04, 32'h0000_0008);
      rd(5'h05, 32'h8000_0000);
      rd(5'h00, 32'h0000_0000);
      end_test("arithmetic");

      p0 = exp_pc;
      run({OPC_CALL, 26'h000_0100}, p0 + 32'h0000_0204, 4'b0100);
      p0 = exp_pc;
      run({OPC_CALL, 26'h3ff_fff0}, p0 - 32'h0000_001c, 4'b0100);
      rd(LINK_REG, p0 + PC_STEP);
      end_test("call");

      // the unused source is driven opposite, so a mixed-up condition input shows
      for (int k = 0; k < 8; k++)
      begin
         sub = SUB_FPZ + 5'(k >> 1);
         c = k[0];
         tk = (sub[0] == c);
         @(posedge clock);
         fp_reg_data <= (sub[1] ? ~c : c) ? 32'hffff_ffff : 32'h8000_0000;
         cop2_cond   <= sub[1] ? c : ~c;
         run(itype(OPC_GROUP_I, sub, 5'(k + 3), 16'hfff8),
             tk ? exp_pc - 32'h0000_000c : exp_pc + PC_STEP, {1'b0, tk, 2'b00});
      end
      end_test("branches");

      @(posedge clock);
      fpu_enable <= 1'b0;
      run(itype(OPC_GROUP_I, SUB_FPZ, 5'h01, 16'h0010), '0, 4'b1010);
      @(posedge clock);
      fpu_present <= 1'b0;
      fpu_enable  <= 1'b1;
      fp_reg_data <= 32'h0000_0001;
      run(itype(OPC_GROUP_I, SUB_FPS, 5'h01, 16'h0010), '0, 4'b1010);
      @(posedge clock);
      fpu_present <= 1'b1;
      cop2_enable <= 1'b0;
      cop2_cond   <= 1'b0;
      run(itype(OPC_GROUP_I, SUB_C2F, 5'h02, 16'h0010), '0, 4'b1010);
      end_test("unusable");

      // pc after an exception is left open, so a fresh reset restarts tracking
      @(posedge clock);
      cop2_enable <= 1'b1;
      rst         <= 1'b1;
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      #1;
      `CHK("pc_reset", PC_RESET, pc)
      exp_pc = PC_RESET;
      rd(5'h00, 32'h0000_0000);
      end_test("second reset");
      give_verdict();
   end
endmodule
